// ==== hdl/fsrp_top.sv ====
// Top of the fuse security and register preload block.
//
// Summary of operation
// [RL1] In preload mode every macrocell register can be forced high or low.
// [RL2] A high pin level loads a one and a low level a zero, whatever the output polarity.
// [RL3] The tester enters preload by holding the high-voltage qualifier input active.
// [RL4] A clock-term pulse in preload copies the pin levels into the selected register bank.
// [RL5] Select low updates register 0 only; select high updates register 1 only.
// [RL6] Once the security fuse is set every fuse reads back as programmed.
// [RL7] The programmer writes the security fuse last because it acts at once.
// [RL8] First legacy mode maps 14394 fuses, zero signature row, keeper off.
// [RL9] Second legacy mode maps 14435 fuses, zero signature row, keeper off.
// [RL10] Native mode maps 14504 fuses with user signature row and user keeper bit.
// [RL11] In legacy modes the checksum covers only the legacy-sized fuse range.
// [RL12] While preload is active the output drivers are released.
`timescale 1ns/1ps
module fsrp_top
    import fsrp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic preloadHv,
    input wire logic clockTerm,
    input wire logic bankSelect,
    input wire logic [MACRO_COUNT-1:0] ioIn,
    output logic [MACRO_COUNT-1:0] ioOut,
    output logic [MACRO_COUNT-1:0] ioOe,
    input wire logic runLoad,
    input wire logic [MACRO_COUNT-1:0] runData0,
    input wire logic [MACRO_COUNT-1:0] runData1,
    input wire logic [MACRO_COUNT-1:0] outEnable,
    input wire logic [MACRO_COUNT-1:0] polarityInvert,
    input wire fsrp_pkg::fsrp_mode_t fuseMode,
    input wire logic keeperFuse,
    input wire logic [SIG_W-1:0] userSignatureRowFuse,
    input wire logic securityFuse,
    input wire logic verifyReq,
    input wire logic [FUSE_AW-1:0] verifyAddr,
    input wire logic fuseRaw,
    input wire logic checksumStart,
    output logic verifyData,
    output logic verifyValid,
    output logic [FUSE_AW-1:0] fuseCount,
    output logic keeperEnable,
    output logic [SIG_W-1:0] userSignatureRow,
    output logic [15:0] checksum,
    output logic checksumDone,
    output logic [MACRO_COUNT-1:0] reg0,
    output logic [MACRO_COUNT-1:0] reg1,
    output logic preloadActive
);
    import fsrp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    fsrp_state_t state;
    fsrp_state_t next_state;
    logic clockTermLast;
    logic preloadPulse;

    // Returns the fuse-map size for a mode.
    function automatic logic [FUSE_AW-1:0] mapSize(input fsrp_mode_t m);
        case (m)
            FSRP_MODE_LEGACY_A: mapSize = FUSES_LEGACY_A;
            FSRP_MODE_LEGACY_B: mapSize = FUSES_LEGACY_B;
            default: mapSize = FUSES_NATIVE;
        endcase
    endfunction

    // Returns whether a mode is a legacy-compatible one.
    function automatic logic isLegacy(input fsrp_mode_t m);
        isLegacy = (m == FSRP_MODE_LEGACY_A) || (m == FSRP_MODE_LEGACY_B);
    endfunction

    // Preload sequencer: enter on the qualifier, load once per clock-term pulse.
    always_comb begin
        next_state = state;
        case (state)
            FSRP_ST_RUN: begin
                if (preloadHv) begin
                    next_state = FSRP_ST_PRELOAD; // [RL3]
                end
            end
            FSRP_ST_PRELOAD: begin
                if (!preloadHv) begin
                    next_state = FSRP_ST_RUN;
                end else if (preloadPulse) begin
                    next_state = FSRP_ST_LOADED;
                end
            end
            FSRP_ST_LOADED: begin
                if (!preloadHv) begin
                    next_state = FSRP_ST_RUN;
                end else if (!clockTerm) begin
                    next_state = FSRP_ST_PRELOAD;
                end
            end
            default: next_state = FSRP_ST_RUN;
        endcase
    end

    // State register.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state <= FSRP_ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Clock-term edge history.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clockTermLast <= 1'b0;
        end else begin
            clockTermLast <= clockTerm;
        end
    end

    // A load happens on the rising edge of the clock term while in preload.
    assign preloadPulse = (state == FSRP_ST_PRELOAD) && clockTerm && !clockTermLast; // [RL4]
    assign preloadActive = (state != FSRP_ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // One macrocell per I/O pin; drivers are released during preload.
    genvar gi;
    generate
        for (gi = 0; gi < MACRO_COUNT; gi++) begin : gMacro
            fsrp_macrocell uCell (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .runLoad(runLoad && !preloadActive),
                .runData0(runData0[gi]),
                .runData1(runData1[gi]),
                .preloadPulse(preloadPulse),
                .selectHigh(bankSelect),
                .pinIn(ioIn[gi]),
                .pinDrive(outEnable[gi] && !preloadActive), // [RL12]
                .polarityInvert(polarityInvert[gi]),
                .reg0(reg0[gi]),
                .reg1(reg1[gi]),
                .pinOut(ioOut[gi]),
                .pinOe(ioOe[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Mode-dependent view of the signature row and keeper bit.
    always_comb begin
        fuseCount = mapSize(fuseMode); // [RL8] [RL9] [RL10]
        keeperEnable = isLegacy(fuseMode) ? 1'b0 : keeperFuse;
        userSignatureRow = isLegacy(fuseMode) ? '0 : userSignatureRowFuse;
    end

    // Verify read: the security fuse forces every fuse to read programmed.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            verifyData <= 1'b0;
            verifyValid <= 1'b0;
        end else begin
            verifyValid <= verifyReq;
            if (verifyReq) begin
                verifyData <= securityFuse ? 1'b1 : fuseRaw; // [RL6]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    logic [FUSE_AW-1:0] sumAddr;
    logic sumBusy;

    // Checksum walks fuses in order; legacy modes stop at their smaller map.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            checksum <= SUM_RESET;
            sumAddr <= '0;
            sumBusy <= 1'b0;
            checksumDone <= 1'b0;
        end else if (checksumStart) begin
            checksum <= SUM_RESET;
            sumAddr <= '0;
            sumBusy <= 1'b1;
            checksumDone <= 1'b0;
        end else if (sumBusy) begin
            checksum <= checksum + {15'h0000, (securityFuse | fuseRaw)}; // [RL11]
            if (sumAddr == mapSize(fuseMode) - 14'd1) begin
                sumBusy <= 1'b0;
                checksumDone <= 1'b1;
            end else begin
                sumAddr <= sumAddr + 14'd1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Preload cycle must load the selected bank from the pins; driver, entry, verify and fuse-map checks follow.
    preload_bank0_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        preloadPulse && !bankSelect |=> reg0 == $past(ioIn)) // [RL5]
        else $error("Bank 0 not loaded from pins.");
    preload_bank1_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        preloadPulse && bankSelect |=> reg1 == $past(ioIn)) // [RL2]
        else $error("Bank 1 not loaded from pins.");
    preload_outputs_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        preloadActive |-> ioOe == '0) // [RL12]
        else $error("Drivers active during preload.");
    preload_entry_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (state == FSRP_ST_RUN) && preloadHv |=> preloadActive) // [RL3]
        else $error("Preload not entered.");
    secure_verify_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        verifyReq && securityFuse |=> verifyValid && verifyData) // [RL6]
        else $error("Secured fuse read back blank.");
    legacy_keeper_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        isLegacy(fuseMode) |-> !keeperEnable && userSignatureRow == '0) // [RL8]
        else $error("Legacy mode kept keeper or signature.");
    native_map_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        fuseMode == FSRP_MODE_NATIVE |-> fuseCount == FUSES_NATIVE) // [RL10]
        else $error("Native fuse count wrong.");
    legacy_b_map_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        fuseMode == FSRP_MODE_LEGACY_B |-> fuseCount == FUSES_LEGACY_B) // [RL9]
        else $error("Second legacy fuse count wrong.");
endmodule

// ==== hdl/fsrp_pkg.sv ====
// Package with the constants shared by the fuse security and register preload block.
package fsrp_pkg;
    // Number of macrocells, each with two registers.
    localparam int MACRO_COUNT = 10;
    // Fuse-map sizes for each compatibility mode.
    localparam logic [13:0] FUSES_LEGACY_A = 14'd14394;
    localparam logic [13:0] FUSES_LEGACY_B = 14'd14435;
    localparam logic [13:0] FUSES_NATIVE = 14'd14504;
    // Width of the fuse address.
    localparam int FUSE_AW = 14;
    // Width of the user signature row.
    localparam int SIG_W = 64;
    // Reset values.
    localparam logic REG_RESET = 1'b0;
    localparam logic [1:0] CHK_RESET = 2'h0;
    localparam logic [15:0] SUM_RESET = 16'h0000;
    // Fuse-map compatibility modes.
    typedef enum logic [1:0] {
        FSRP_MODE_NATIVE = 2'h0,
        FSRP_MODE_LEGACY_A = 2'h1,
        FSRP_MODE_LEGACY_B = 2'h2
    } fsrp_mode_t;
    // Preload sequencer states, one-hot.
    typedef enum logic [2:0] {
        FSRP_ST_RUN = 3'b001,
        FSRP_ST_PRELOAD = 3'b010,
        FSRP_ST_LOADED = 3'b100
    } fsrp_state_t;
endpackage

// ==== hdl/fsrp_macrocell.sv ====
// One macrocell: two registers with preload and a pin driver.
`timescale 1ns/1ps
module fsrp_macrocell
    import fsrp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic runLoad,
    input wire logic runData0,
    input wire logic runData1,
    input wire logic preloadPulse,
    input wire logic selectHigh,
    input wire logic pinIn,
    input wire logic pinDrive,
    input wire logic polarityInvert,
    output logic reg0,
    output logic reg1,
    output logic pinOut,
    output logic pinOe
);
    // Register 0: the pin level is loaded as-is, ignoring output polarity.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg0 <= REG_RESET;
        end else if (preloadPulse && !selectHigh) begin
            reg0 <= pinIn; // [RL1] [RL2] [RL5]
        end else if (runLoad) begin
            reg0 <= runData0;
        end
    end

    // Register 1: loaded when the select pin is high.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            reg1 <= REG_RESET;
        end else if (preloadPulse && selectHigh) begin
            reg1 <= pinIn; // [RL1] [RL2] [RL5]
        end else if (runLoad) begin
            reg1 <= runData1;
        end
    end

    // Output driver applies the configured polarity and is enabled by the caller.
    always_comb begin
        pinOut = reg0 ^ polarityInvert;
        pinOe = pinDrive;
    end
endmodule

// ==== tb/fsrp_tester.sv ====
// Tester model that drives preload cycles onto the device pins.
`timescale 1ns/1ps
module fsrp_tester
    import fsrp_pkg::*;
(
    input wire logic ref_clk,
    output logic preloadHv,
    output logic clockTerm,
    output logic bankSelect,
    output logic [MACRO_COUNT-1:0] ioIn
);
    // Idle levels at time zero.
    initial begin
        preloadHv = 1'b0;
        clockTerm = 1'b0;
        bankSelect = 1'b0;
        ioIn = 10'h000;
    end
    // One preload cycle; the qualifier stands two falling edges before the clock term rises.
    task automatic preload(input logic bank, input logic [MACRO_COUNT-1:0] data);
        @(negedge ref_clk);
        preloadHv = 1'b1;
        @(negedge ref_clk);
        bankSelect = bank;
        ioIn = data;
        @(negedge ref_clk);
        clockTerm = 1'b1;
        @(negedge ref_clk);
        clockTerm = 1'b0;
    endtask
    // Leaves preload; released pins show the inverse so stale data is never mistaken.
    task automatic leave();
        @(negedge ref_clk);
        preloadHv = 1'b0;
        ioIn = ~ioIn;
    endtask
endmodule

// ==== tb/tb_fsrp_top.sv ====
// Self-checking testbench for the fuse security and register preload block.
`timescale 1ns/1ps
module tb_fsrp_top;
    import fsrp_pkg::*;
    typedef struct {logic bank; logic [9:0] data; logic [9:0] pol; logic [9:0] exp;} fsrp_row_t;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic runLoad = 1'b0;
    logic [9:0] runData0 = 10'h000;
    logic [9:0] runData1 = 10'h000;
    logic [9:0] outEnable = 10'h3FF;
    logic [9:0] polarityInvert = 10'h000;
    fsrp_mode_t fuseMode = FSRP_MODE_NATIVE;
    logic keeperFuse = 1'b1;
    logic [63:0] sigFuse = 64'hA5C3_0F96_1E2D_3C4B;
    logic securityFuse = 1'b0;
    logic verifyReq = 1'b0;
    logic [13:0] verifyAddr = 14'h0005;
    logic fuseRaw = 1'b0;
    logic checksumStart = 1'b0;
    logic preloadHv, clockTerm, bankSelect, verifyData, verifyValid, keeperEnable;
    logic checksumDone, preloadActive;
    logic [9:0] ioIn, ioOut, ioOe, reg0, reg1;
    logic [13:0] fuseCount;
    logic [63:0] userSignatureRow;
    logic [15:0] checksum;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    fsrp_row_t rows [4] = '{'{0, 10'h3FF, 10'h000, 10'h3FF}, '{0, 10'h155, 10'h3FF, 10'h155},
        '{1, 10'h2AA, 10'h155, 10'h2AA}, '{1, 10'h000, 10'h3FF, 10'h000}};
    logic [13:0] sizes [3] = '{FUSES_NATIVE, FUSES_LEGACY_A, FUSES_LEGACY_B};
    fsrp_tester tester (.ref_clk(ref_clk), .preloadHv(preloadHv), .clockTerm(clockTerm),
        .bankSelect(bankSelect), .ioIn(ioIn));
    fsrp_top dut (.ref_clk(ref_clk), .nrst(nrst), .preloadHv(preloadHv),
        .clockTerm(clockTerm), .bankSelect(bankSelect), .ioIn(ioIn), .ioOut(ioOut),
        .ioOe(ioOe), .runLoad(runLoad), .runData0(runData0), .runData1(runData1),
        .outEnable(outEnable), .polarityInvert(polarityInvert), .fuseMode(fuseMode),
        .keeperFuse(keeperFuse), .userSignatureRowFuse(sigFuse),
        .securityFuse(securityFuse), .verifyReq(verifyReq), .verifyAddr(verifyAddr),
        .fuseRaw(fuseRaw), .checksumStart(checksumStart), .verifyData(verifyData),
        .verifyValid(verifyValid), .fuseCount(fuseCount), .keeperEnable(keeperEnable),
        .userSignatureRow(userSignatureRow), .checksum(checksum),
        .checksumDone(checksumDone), .reg0(reg0), .reg1(reg1),
        .preloadActive(preloadActive));
    ////////////////////////////////////////////////////////////////////////////////
    // Clock of 100 MHz.
    always #5 ref_clk = ~ref_clk;
    // Compares one value and reports a difference.
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            stop_test();
        end
    end
    // Main sequence.
    initial begin
        repeat (16) @(negedge ref_clk);
        check("reset reg0", reg0, 10'h000);
        check("reset valid", verifyValid, 1'b0);
        check("reset oe", ioOe, outEnable);
        nrst = 1'b1;
        foreach (rows[i]) begin
            polarityInvert = rows[i].pol;
            tester.preload(rows[i].bank, rows[i].data);
            check("preloadActive", preloadActive, 1'b1);
            check("ioOe released", ioOe, 10'h000);
            check("bank", rows[i].bank ? reg1 : reg0, rows[i].exp);
        end
        runData1 = 10'h3FF;
        runLoad = 1'b1;
        @(negedge ref_clk);
        runLoad = 1'b0;
        check("runLoad ignored", reg1, 10'h000);
        tester.leave();
        runData0 = 10'h155;
        runLoad = 1'b1;
        repeat (2) @(negedge ref_clk);
        runLoad = 1'b0;
        check("run reg1", reg1, 10'h3FF);
        check("ioOut", ioOut, 10'h2AA);
        check("ioOe", ioOe, 10'h3FF);
        // Code 3 is not a mode of its own and must decode as native.
        for (int m = 0; m < 4; m++) begin
            fuseMode = fsrp_mode_t'(m[1:0]);
            @(negedge ref_clk);
            check("fuseCount", fuseCount, sizes[m % 3]);
            check("keeper", keeperEnable, m % 3 == 0 ? keeperFuse : 1'b0);
            check("sig", userSignatureRow, m % 3 == 0 ? sigFuse : 64'h0);
        end
        // The security fuse goes in last; each pass verifies a blank fuse, then walks a checksum.
        for (int s = 0; s < 2; s++) begin
            securityFuse = s[0];
            fuseRaw = 1'b0;
            @(negedge ref_clk);
            verifyReq = 1'b1;
            @(negedge ref_clk);
            verifyReq = 1'b0;
            check("verifyValid", verifyValid, 1'b1);
            check("verifyData", verifyData, s[0]);
            fuseMode = fsrp_mode_t'(2'(s + 1));
            fuseRaw = !s[0];
            checksumStart = 1'b1;
            @(negedge ref_clk);
            checksumStart = 1'b0;
            for (int w = 0; w < 20000 && checksumDone !== 1'b1; w++) @(negedge ref_clk);
            check("checksumDone", checksumDone, 1'b1);
            check("checksum", checksum, {2'h0, sizes[s + 1]});
        end
        // A reset in mid-run clears the banks and the result flags at once.
        nrst = 1'b0;
        @(negedge ref_clk);
        check("mid reset reg0", reg0, 10'h000);
        check("mid reset done", checksumDone, 1'b0);
        check("mid reset data", verifyData, 1'b0);
        nrst = 1'b1;
        @(negedge ref_clk);
        check("after reset oe", ioOe, outEnable);
        stop_test();
    end
endmodule
